// ==== core/ctmr_pkg.sv ====
/*
 * Shared constants for the compact timer: register offsets, field
 * positions, reset values and mode encodings.
 * Assumes a 32-bit APB with byte addresses; every register sits in the
 * low byte of one aligned word.
 */
package ctmr_pkg;

   // ==========================================================
   // Widths
   localparam int CNT_W   = 16;
   localparam int CMP_P_W = 8;

   // ==========================================================
   // Register offsets (byte addresses)
   localparam logic [7:0] OFS_CTRL0   = 8'h00;
   localparam logic [7:0] OFS_CTRL1   = 8'h04;
   localparam logic [7:0] OFS_CNT_LO  = 8'h08;
   localparam logic [7:0] OFS_CNT_HI  = 8'h0C;
   localparam logic [7:0] OFS_CMPA_LO = 8'h10;
   localparam logic [7:0] OFS_CMPA_HI = 8'h14;
   localparam logic [7:0] OFS_CMPP    = 8'h18;
   localparam logic [7:0] OFS_FLAGS   = 8'h1C;

   // ==========================================================
   // Field positions
   localparam int B_PAUSE     = 7;
   localparam int B_CKSEL_LSB = 4;
   localparam int B_ENABLE    = 3;
   localparam int B_MODE_LSB  = 6;
   localparam int B_ACT_LSB   = 4;
   localparam int B_OC        = 3;
   localparam int B_POL       = 2;
   localparam int B_SWAP      = 1;
   localparam int B_CLRSEL    = 0;
   localparam int B_FLAG_A    = 0;
   localparam int B_FLAG_P    = 1;

   // ==========================================================
   // Reset values and the full-scale PWM duty
   localparam logic [7:0]  RST_BYTE   = 8'h00;
   localparam logic [15:0] RST_WORD   = 16'h0000;
   localparam logic [16:0] FULL_SCALE = 17'h10000;

   // ==========================================================
   // Encodings
   typedef enum logic [1:0]
   {
      MODE_COMPARE = 2'b00,
      MODE_UNDEF   = 2'b01,
      MODE_PWM     = 2'b10,
      MODE_TIMER   = 2'b11
   } ctmr_mode_t;

   typedef enum logic [1:0]
   {
      ACT_NONE   = 2'b00,
      ACT_LOW    = 2'b01,
      ACT_HIGH   = 2'b10,
      ACT_TOGGLE = 2'b11
   } ctmr_act_t;

   localparam logic [1:0] PWM_INACTIVE = 2'b00;
   localparam logic [1:0] PWM_ACTIVE   = 2'b01;
   localparam logic [1:0] PWM_RUN      = 2'b10;

endpackage

// ==== core/ctmr_match_if.sv ====
/*
 * Carrier between the timer core and its comparator unit.
 * Assumes both ends share one clock domain; all signals combinational.
 */
interface ctmr_match_if #(
   parameter int CNT_W = ctmr_pkg::CNT_W,
   parameter int P_W   = ctmr_pkg::CMP_P_W
);
   logic [CNT_W:0]   count_inc;
   logic [CNT_W-1:0] cmp_a;
   logic [P_W-1:0]   cmp_p;
   logic             hit_a;
   logic             hit_p;

   modport core (output count_inc, output cmp_a, output cmp_p,
                 input hit_a, input hit_p);
   modport unit (input count_inc, input cmp_a, input cmp_p,
                 output hit_a, output hit_p);
endinterface

// ==== core/ctmr_match.sv ====
/*
 * Comparators A and P of the compact timer.
 * Assumes count_inc is the incremented count with its carry on top.
 */
module ctmr_match #(
   parameter int CNT_W = ctmr_pkg::CNT_W,
   parameter int P_W   = ctmr_pkg::CMP_P_W
)(
   ctmr_match_if.unit mif  // Count and compare values in, hits out
);
   import ctmr_pkg::*;

   generate
      if (P_W >= CNT_W || P_W < 1)
      begin : g_bad
         $error("ctmr_match: P_W must lie between 1 and CNT_W-1");
      end
   endgenerate

   // ==========================================================
   // Comparator A: all counter bits; zero never matches
   assign mif.hit_a = (mif.cmp_a != '0) &&
                      (mif.count_inc == {1'b0, mif.cmp_a});

   // ==========================================================
   // Comparator P: upper bits only, so hits land on 256-count steps;
   // zero means the carry out of the full counter
   assign mif.hit_p = (mif.cmp_p != '0) ?
      (mif.count_inc == {1'b0, mif.cmp_p, {(CNT_W-P_W){1'b0}}}) :
      mif.count_inc[CNT_W];
endmodule

// ==== core/ctmr_top.sv ====
/*
 * Compact 16-bit timer with compare-match, timer and PWM modes,
 * reached over APB.
 * Assumes count_tick is a one-cycle pulse per tick of the selected
 * module clock, made outside from clk_select.
 */
module ctmr_top #(
   parameter int ADDR_W = 8
)(
   input  wire logic              pclk,           // Bus clock, 25 MHz
   input  wire logic              presetn,        // Async reset, low
   input  wire logic              psel,           // APB select
   input  wire logic              penable,        // APB access phase
   input  wire logic              pwrite,         // APB write
   input  wire logic [ADDR_W-1:0] paddr,          // APB byte address
   input  wire logic [31:0]       pwdata,         // APB write data
   input  wire logic [3:0]        pstrb,          // APB byte strobes
   output logic      [31:0]       prdata,         // APB read data
   output logic                   pready,         // APB ready
   output logic                   pslverr,        // APB error
   input  wire logic              count_tick,     // Module clock tick
   output logic      [2:0]        clk_select,     // Tick source select
   output logic                   timer_out,      // Output pin level
   output logic                   timer_out_used, // Pin owned by timer
   output logic                   match_a_flag,   // A match request
   output logic                   match_p_flag    // P match request
);
   import ctmr_pkg::*;

   generate
      if (ADDR_W < 8)
      begin : g_bad
         $error("ctmr_top: ADDR_W must be at least 8");
      end
   endgenerate

   // ==========================================================
   // Register state
   logic             pause_r;
   logic [2:0]       cksel_r;
   logic             enable_r;
   ctmr_mode_t       mode_r;
   logic [1:0]       act_r;
   logic             oc_r;
   logic             pol_r;
   logic             swap_r;
   logic             clrsel_r;
   logic [15:0]      cmp_a_r;
   logic [7:0]       cmp_p_r;
   logic [15:0]      cnt_r;
   logic             flag_a_r;
   logic             flag_p_r;
   logic             en_d_r;
   logic             cm_level_r;
   logic             timer_out_r;
   logic             used_r;
   logic [31:0]      prdata_r;
   logic             pready_r;
   logic             pslverr_r;

   // ==========================================================
   // Bus decode
   logic             setup;
   logic             wr;
   logic             hi_zero;
   logic             hit;
   logic [7:0]       rd_byte;

   assign setup   = psel & ~penable;
   // Low byte holds all data, so only its strobe matters
   assign wr      = psel & penable & pready_r & pwrite & pstrb[0];
   assign hi_zero = (paddr >> 8) == {ADDR_W{1'b0}};

   always_comb
   begin
      rd_byte = RST_BYTE;
      hit     = hi_zero;
      case (paddr[7:0])
         OFS_CTRL0:   rd_byte = {pause_r, cksel_r, enable_r, 3'b000};
         OFS_CTRL1:   rd_byte = {mode_r, act_r, oc_r, pol_r, swap_r,
                                 clrsel_r};
         OFS_CNT_LO:  rd_byte = cnt_r[7:0];
         OFS_CNT_HI:  rd_byte = cnt_r[15:8];
         OFS_CMPA_LO: rd_byte = cmp_a_r[7:0];
         OFS_CMPA_HI: rd_byte = cmp_a_r[15:8];
         OFS_CMPP:    rd_byte = cmp_p_r;
         OFS_FLAGS:   rd_byte = {6'b000000, flag_p_r, flag_a_r};
         default:     hit     = 1'b0;
      endcase
   end

   // Answer one cycle after setup; read data latched then
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_r  <= 1'b0;
         prdata_r  <= 32'h00000000;
         pslverr_r <= 1'b0;
      end
      else
      begin
         pready_r <= setup;
         if (setup)
         begin
            prdata_r  <= (hit && !pwrite) ? {24'h000000, rd_byte} :
                                            32'h00000000;
            pslverr_r <= ~hit;
         end
      end
   end

   // ==========================================================
   // Control and compare registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pause_r  <= RST_BYTE[B_PAUSE];
         cksel_r  <= RST_BYTE[B_CKSEL_LSB +: 3];
         enable_r <= RST_BYTE[B_ENABLE];
         mode_r   <= MODE_COMPARE;
         act_r    <= RST_BYTE[B_ACT_LSB +: 2];
         oc_r     <= RST_BYTE[B_OC];
         pol_r    <= RST_BYTE[B_POL];
         swap_r   <= RST_BYTE[B_SWAP];
         clrsel_r <= RST_BYTE[B_CLRSEL];
         cmp_a_r  <= RST_WORD;
         cmp_p_r  <= RST_BYTE;
      end
      else if (wr && hi_zero)
      begin
         case (paddr[7:0])
            OFS_CTRL0:
            begin
               pause_r  <= pwdata[B_PAUSE];
               cksel_r  <= pwdata[B_CKSEL_LSB +: 3];
               enable_r <= pwdata[B_ENABLE];
            end
            OFS_CTRL1:
            begin
               mode_r   <= ctmr_mode_t'(pwdata[B_MODE_LSB +: 2]);
               act_r    <= pwdata[B_ACT_LSB +: 2];
               oc_r     <= pwdata[B_OC];
               pol_r    <= pwdata[B_POL];
               swap_r   <= pwdata[B_SWAP];
               clrsel_r <= pwdata[B_CLRSEL];
            end
            OFS_CMPA_LO: cmp_a_r[7:0]  <= pwdata[7:0];
            OFS_CMPA_HI: cmp_a_r[15:8] <= pwdata[7:0];
            OFS_CMPP:    cmp_p_r       <= pwdata[7:0];
            default:     ;
         endcase
      end
   end

   // ==========================================================
   // Counter and comparators
   ctmr_match_if mif ();

   ctmr_match #(.CNT_W(CNT_W), .P_W(CMP_P_W)) u_match (.mif(mif));

   logic             run;
   logic             en_rise;
   logic             is_pwm;
   logic             clr;
   logic             set_a;
   logic             set_p;
   logic             flag_wr;

   assign mif.count_inc = {1'b0, cnt_r} + 17'h00001;
   assign mif.cmp_a     = cmp_a_r;
   assign mif.cmp_p     = cmp_p_r;
   assign run           = enable_r & ~pause_r & count_tick;
   assign en_rise       = enable_r & ~en_d_r;
   assign is_pwm        = mode_r == MODE_PWM;
   // PWM picks the clearing comparator from swap, others from clear-select
   assign clr    = is_pwm ? (swap_r ? mif.hit_a : mif.hit_p) :
                   (clrsel_r ? mif.hit_a : mif.hit_p);
   assign set_a  = run & mif.hit_a;
   assign set_p  = run & mif.hit_p & (is_pwm | ~clrsel_r);
   assign flag_wr = wr && hi_zero && paddr[7:0] == OFS_FLAGS;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         en_d_r <= 1'b0;
      else
         en_d_r <= enable_r;
   end

   // Falling enable simply stops run, keeping the residual count
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cnt_r <= RST_WORD;
      else if (en_rise)
         cnt_r <= RST_WORD;
      else if (run)
         cnt_r <= clr ? RST_WORD : mif.count_inc[15:0];
   end

   // Write one clears; a same-cycle match wins over the clear
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         flag_a_r <= 1'b0;
         flag_p_r <= 1'b0;
      end
      else
      begin
         flag_a_r <= set_a | (flag_a_r &
                     ~(flag_wr & pwdata[B_FLAG_A]));
         flag_p_r <= set_p | (flag_p_r &
                     ~(flag_wr & pwdata[B_FLAG_P]));
      end
   end

   // ==========================================================
   // Output pin
   logic [16:0]      duty;
   logic             pwm_active;
   logic             pwm_lvl;
   logic             pin_val;

   assign duty = swap_r ? ((cmp_p_r == RST_BYTE) ? FULL_SCALE :
                           {1'b0, cmp_p_r, 8'h00}) :
                          {1'b0, cmp_a_r};
   // Count never reaches the period, so a long duty stays active
   assign pwm_active = {1'b0, cnt_r} < duty;

   always_comb
   begin
      case (act_r)
         PWM_INACTIVE: pwm_lvl = 1'b0;
         PWM_ACTIVE:   pwm_lvl = 1'b1;
         PWM_RUN:      pwm_lvl = pwm_active;
         default:      pwm_lvl = 1'b0;
      endcase
   end

   assign pin_val = pol_r ^ (is_pwm ? ~(oc_r ^ pwm_lvl) :
                             cm_level_r);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cm_level_r <= 1'b0;
      else if (en_rise)
         cm_level_r <= oc_r;
      else if (set_a && mode_r == MODE_COMPARE)
      begin
         unique case (act_r)
            ACT_NONE:   cm_level_r <= cm_level_r;
            ACT_LOW:    cm_level_r <= 1'b0;
            ACT_HIGH:   cm_level_r <= 1'b1;
            ACT_TOGGLE: cm_level_r <= ~cm_level_r;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         timer_out_r <= 1'b0;
         used_r      <= 1'b0;
      end
      else
      begin
         used_r      <= mode_r == MODE_COMPARE || is_pwm;
         timer_out_r <= (mode_r == MODE_COMPARE || is_pwm) ?
                        pin_val : 1'b0;
      end
   end

   assign prdata         = prdata_r;
   assign pready         = pready_r;
   assign pslverr        = pslverr_r;
   assign clk_select     = cksel_r;
   assign timer_out      = timer_out_r;
   assign timer_out_used = used_r;
   assign match_a_flag   = flag_a_r;
   assign match_p_flag   = flag_p_r;

   // ==========================================================
   // Checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_tick;
      run && !en_rise;
   endsequence

   sequence s_hit_a_cm;
      s_tick ##0 mif.hit_a && mode_r == MODE_COMPARE;
   endsequence

   property p_enable_rise;
      en_rise |=> cnt_r == RST_WORD;
   endproperty
   a_enable_rise: assert property (p_enable_rise)
      else $error("counter not cleared on enable rise");

   property p_pause_hold;
      enable_r && pause_r && !en_rise |=> cnt_r == $past(cnt_r);
   endproperty
   a_pause_hold: assert property (p_pause_hold)
      else $error("counter moved while paused");

   property p_step;
      s_tick ##0 !clr |=> cnt_r == $past(cnt_r) + 16'h0001;
   endproperty
   a_step: assert property (p_step)
      else $error("counter did not step by one");

   property p_clear_p;
      s_tick ##0 (!is_pwm && !clrsel_r && mif.hit_p)
         |=> cnt_r == RST_WORD && flag_p_r;
   endproperty
   a_clear_p: assert property (p_clear_p)
      else $error("P match did not clear counter and flag");

   property p_no_p_flag;
      !is_pwm && clrsel_r && !flag_p_r |=> !flag_p_r;
   endproperty
   a_no_p_flag: assert property (p_no_p_flag)
      else $error("P flag set with clear-select high");

   property p_a_zero;
      !is_pwm && clrsel_r && cmp_a_r == RST_WORD && !flag_a_r
         |=> !flag_a_r;
   endproperty
   a_a_zero: assert property (p_a_zero)
      else $error("A flag set with A value zero");

   property p_pin_high;
      s_hit_a_cm ##0 act_r == ACT_HIGH |=> cm_level_r ##1
         timer_out_r == (pol_r ^ 1'b1);
   endproperty
   a_pin_high: assert property (p_pin_high)
      else $error("pin not driven high on A match");

   property p_pwm_full;
      is_pwm && act_r == PWM_RUN && !swap_r && oc_r && !pol_r &&
      ({1'b0, cnt_r} < {1'b0, cmp_a_r}) |=> timer_out_r;
   endproperty
   a_pwm_full: assert property (p_pwm_full)
      else $error("PWM output not active inside duty");

   property p_pwm_forced;
      is_pwm && act_r == PWM_INACTIVE |=> timer_out_r ==
         ($past(pol_r) ^ ~$past(oc_r));
   endproperty
   a_pwm_forced: assert property (p_pwm_forced)
      else $error("forced inactive PWM level wrong");

   property p_set_wins;
      set_a && flag_wr && pwdata[B_FLAG_A] |=> flag_a_r;
   endproperty
   a_set_wins: assert property (p_set_wins)
      else $error("A flag lost to same-cycle clear");

   property p_timer_pin;
      mode_r == MODE_TIMER |=> !timer_out_used && !timer_out;
   endproperty
   a_timer_pin: assert property (p_timer_pin)
      else $error("pin driven in timer mode");
endmodule

// ==== test/test_compact_timer_compare_pwm.sv ====
/*
 * Self-checking bench for the compact timer: APB tasks and a reference
 * model compared with the design at every read and every cycle.
 * Assumes ctmr_pkg and the core files are compiled first.
 */
module test_compact_timer_compare_pwm;
   timeunit 1ns;
   timeprecision 1ps;
   import ctmr_pkg::*;

   logic        pclk, presetn, psel, penable, pwrite, count_tick, rnd_tick;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0]  pstrb;
   logic [2:0]  clk_select;
   logic        pready, pslverr, timer_out, timer_out_used;
   logic        match_a_flag, match_p_flag;
   int          errors, num_checks, seed, hi;
   logic [7:0]  m_c0, m_c1, m_al, m_ah, m_p, m_rd;
   logic [15:0] m_cnt;
   logic        m_fa, m_fp, m_lvl, m_pin, m_en_d, m_err;
   int          m_on;
   // PWM cases: compare A, control 1, window, active cycles
   localparam int PA[7] = '{64, 300, 64, 64, 512, 64, 64};
   localparam int PC[7] = '{8'hA9, 8'hA8, 8'hA0, 8'hAC, 8'hAA, 8'h88, 8'h98};
   localparam int PW[7] = '{256, 256, 256, 256, 512, 256, 256};
   localparam int PE[7] = '{64, 256, 192, 192, 256, 0, 256};

   ctmr_top dut (
      .pclk           (pclk),
      .presetn        (presetn),
      .psel           (psel),
      .penable        (penable),
      .pwrite         (pwrite),
      .paddr          (paddr),
      .pwdata         (pwdata),
      .pstrb          (pstrb),
      .prdata         (prdata),
      .pready         (pready),
      .pslverr        (pslverr),
      .count_tick     (count_tick),
      .clk_select     (clk_select),
      .timer_out      (timer_out),
      .timer_out_used (timer_out_used),
      .match_a_flag   (match_a_flag),
      .match_p_flag   (match_p_flag)
   );

   initial
   begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end

   always @(posedge pclk)
      count_tick <= rnd_tick ? 1'($random(seed)) : 1'b1;

   // ==========================================================
   // Reference model, state changes at the same edges as the design
   always @(posedge pclk or negedge presetn)
   begin : model
      logic [16:0] nxt;
      logic        ha, hp, clr, wr;
      logic [1:0]  md;
      if (!presetn)
      begin
         {m_c0, m_c1, m_al, m_ah, m_p, m_rd, m_cnt} = '0;
         {m_fa, m_fp, m_lvl, m_en_d, m_err} = '0;
         m_pin <= 1'b0;
         m_on = 0;
      end
      else
      begin
         md = m_c1[7:6];
         if (psel && !penable)
         begin
            m_err = 1'b0;
            case (paddr)
               OFS_CTRL0:   m_rd = m_c0;
               OFS_CTRL1:   m_rd = m_c1;
               OFS_CNT_LO:  m_rd = m_cnt[7:0];
               OFS_CNT_HI:  m_rd = m_cnt[15:8];
               OFS_CMPA_LO: m_rd = m_al;
               OFS_CMPA_HI: m_rd = m_ah;
               OFS_CMPP:    m_rd = m_p;
               OFS_FLAGS:   m_rd = {6'h00, m_fp, m_fa};
               default:     {m_err, m_rd} = 9'h100;
            endcase
         end
         wr = psel && penable && pready && pwrite && pstrb[0];
         // Clear first so a match in the same cycle wins
         if (wr && paddr == OFS_FLAGS)
            {m_fp, m_fa} = {m_fp, m_fa} & ~pwdata[1:0];
         m_pin <= (md == MODE_COMPARE) & (m_c1[B_POL] ^ m_lvl);
         if (m_c0[B_ENABLE] && !m_en_d)
         begin
            m_cnt = RST_WORD;
            m_lvl = m_c1[B_OC];
         end
         else if (m_c0[B_ENABLE] && !m_c0[B_PAUSE] && count_tick)
         begin
            nxt = {1'b0, m_cnt} + 17'h00001;
            hp = (m_p == 8'h00) ? nxt[16] :
                 (nxt[15:0] == {m_p, 8'h00});
            ha = ({m_ah, m_al} != 16'h0000) &&
                 (nxt[15:0] == {m_ah, m_al});
            clr = (md == MODE_PWM) ? (m_c1[B_SWAP] ? ha : hp)
                : (m_c1[B_CLRSEL] ? ha : hp);
            m_fa = m_fa | ha;
            m_fp = m_fp | (hp && (md == MODE_PWM || !m_c1[B_CLRSEL]));
            if (ha && md == MODE_COMPARE)
               case (ctmr_act_t'(m_c1[5:4]))
                  ACT_LOW:    m_lvl = 1'b0;
                  ACT_HIGH:   m_lvl = 1'b1;
                  ACT_TOGGLE: m_lvl = ~m_lvl;
                  default:    m_lvl = m_lvl;
               endcase
            m_cnt = clr ? RST_WORD : nxt[15:0];
         end
         m_on = m_c0[B_ENABLE] ? ((m_on < 3) ? m_on + 1 : 3) : 0;
         m_en_d = m_c0[B_ENABLE];
         if (wr)
            case (paddr)
               OFS_CTRL0:   m_c0 = pwdata[7:0] & 8'hF8;
               OFS_CTRL1:   m_c1 = pwdata[7:0];
               OFS_CMPA_LO: m_al = pwdata[7:0];
               OFS_CMPA_HI: m_ah = pwdata[7:0];
               OFS_CMPP:    m_p = pwdata[7:0];
               default:     m_p = m_p;
            endcase
      end
   end

   // ==========================================================
   // Checks
   task automatic chk(input logic [31:0] got, exp, input string msg);
      num_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("[FAIL] %0t %s: got %0h expected %0h",
                  $time, msg, got, exp);
      end
   endtask

   always @(negedge pclk)
      if (presetn)
      begin
         chk(match_a_flag, m_fa, "flag A");
         chk(match_p_flag, m_fp, "flag P");
         chk(clk_select, m_c0[6:4], "clock select");
         if (m_on >= 2)
         begin
            if (m_c1[7] == m_c1[6])
               chk(timer_out, m_pin, "pin level");
            chk(timer_out_used, !m_c1[6], "pin owner");
         end
      end

   // Call right after a rising edge; returns one edge after release
   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] v);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h000000, v};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      chk(pslverr, m_err, "bus error");
      if (!w)
         chk(prdata, {24'h000000, m_rd}, "read data");
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic rd(input logic [7:0] a);
      apb(1'b0, a, 8'h00);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      apb(1'b1, a, v);
   endtask

   task automatic done(input string s);
      $display("test %s finished", s);
   endtask

   task automatic print_verdict;
      $display("checks %0d, mismatches %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   initial
   begin
      repeat (95000) @(posedge pclk);
      errors++;
      print_verdict;
   end

   // ==========================================================
   // Scenarios
   initial
   begin
      {psel, penable, pwrite, rnd_tick, presetn} = '0;
      {paddr, pwdata} = '0;
      pstrb = 4'hF;
      seed = 32'h3c30;
      errors = 0;
      num_checks = 0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (int a = 0; a <= 8'h20; a += 4) rd(8'(a));
      done("reset values");
      rnd_tick <= 1'b1;
      wr(OFS_CMPA_LO, 8'($random(seed)));
      wr(OFS_CMPA_HI, 8'($random(seed)));
      wr(OFS_CMPP, 8'($random(seed)));
      wr(OFS_CNT_LO, 8'hFF);
      pstrb <= 4'hE;
      wr(OFS_CMPP, 8'h5A);
      pstrb <= 4'hF;
      for (int a = 0; a <= 8'h20; a += 4) rd(8'(a));
      done("register access");
      rnd_tick <= 1'b0;
      wr(OFS_CMPA_LO, 8'h05);
      wr(OFS_CMPA_HI, 8'h00);
      for (int i = 0; i < 8; i++)
      begin
         wr(OFS_CTRL0, 8'h00);
         wr(OFS_CTRL1, {2'b00, 2'(i), 1'(i >> 2), 1'(i >> 1), 2'b01});
         wr(OFS_FLAGS, 8'h03);
         wr(OFS_CTRL0, 8'(8'h08 | (i << 4)));
         repeat (23) @(posedge pclk);
         rd(OFS_CNT_LO);
         // Clears every 3 cycles against a 5-cycle match: one collides
         repeat (5) wr(OFS_FLAGS, 8'h03);
      end
      done("compare actions");
      wr(OFS_CMPA_LO, 8'h80);
      wr(OFS_CMPP, 8'h01);
      for (int m = 0; m < 2; m++)
      begin
         wr(OFS_CTRL0, 8'h00);
         wr(OFS_CTRL1, m ? 8'hC0 : 8'h30);
         wr(OFS_FLAGS, 8'h03);
         wr(OFS_CTRL0, 8'h08);
         rnd_tick <= 1'b1;
         repeat (700) @(posedge pclk);
         rd(OFS_CNT_HI);
         rd(OFS_CNT_LO);
      end
      done("clear on P match");
      wr(OFS_CTRL0, 8'h88);
      rd(OFS_CNT_LO);
      rd(OFS_CNT_LO);
      wr(OFS_CTRL0, 8'h08);
      repeat (10) @(posedge pclk);
      rd(OFS_CNT_LO);
      wr(OFS_CTRL0, 8'h00);
      repeat (10) @(posedge pclk);
      rd(OFS_CNT_LO);
      wr(OFS_CTRL0, 8'h08);
      rd(OFS_CNT_LO);
      done("pause and enable");
      rnd_tick <= 1'b0;
      wr(OFS_CTRL0, 8'h00);
      wr(OFS_CMPP, 8'h00);
      wr(OFS_CTRL1, 8'h00);
      wr(OFS_FLAGS, 8'h03);
      wr(OFS_CTRL0, 8'h08);
      repeat (65520) @(posedge pclk);
      rd(OFS_CNT_HI);
      repeat (20) @(posedge pclk);
      rd(OFS_CNT_LO);
      done("overflow");
      for (int k = 0; k < 7; k++)
      begin
         wr(OFS_CTRL0, 8'h00);
         wr(OFS_CMPA_LO, 8'(PA[k]));
         wr(OFS_CMPA_HI, 8'(PA[k] >> 8));
         wr(OFS_CMPP, 8'h01);
         wr(OFS_CTRL1, 8'(PC[k]));
         wr(OFS_CTRL0, 8'h08);
         repeat (1100) @(posedge pclk);
         hi = 0;
         repeat (PW[k])
         begin
            // Settled level, away from the edge that launches it
            @(negedge pclk);
            hi += int'(timer_out === 1'b1);
         end
         @(posedge pclk);
         chk(hi, PE[k], "active cycles");
      end
      done("pwm");
      print_verdict;
   end
endmodule
